// ### sim/ecu_master_model.sv
// Master on the open-drain link: sends triggers and times reply edges.
// Assumes the bench pulls the line up and ands in every pull-down.
`timescale 1ns/10ps
module ecu_master_model (
  // Clock
  input wire logic i_clk_sys,
  // Line
  input wire logic i_line,
  output logic o_pull
);
  int gap_ut [7];
  logic got;
  initial o_pull = 1'b0;
  // Spans are in unit times; ut is clocks per unit time
  task automatic poll(input int low_ut, input int ut);
    int n;
    int t;
    int last;
    logic prev;
    n = 0;
    last = 0;
    prev = 1'b0;
    @(posedge i_clk_sys);
    o_pull <= 1'b1;
    repeat (low_ut * ut) @(posedge i_clk_sys);
    o_pull <= 1'b0;
    t = low_ut * ut;
    while (n < 7 && t - last < 100 * ut) begin
      @(posedge i_clk_sys);
      t++;
      if (prev && !i_line) begin
        gap_ut[n] = (t - last) / ut;
        last = t;
        n++;
      end
      prev = i_line;
    end
    got = (n == 7);
    repeat (8 * ut) @(posedge i_clk_sys);
  endtask
endmodule

// ### sim/pwm_sensor_link_options_test.sv
// Self-checking bench of the sensor link: registers, frames, addressing.
// Assumes the master model and the checker are compiled with the design.
`timescale 1ns/10ps
module pwm_sensor_link_options_test
  import sensor_link_pkg::*;
;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  bus_req_t i_bus = '0;
  logic [11:0] i_sample = 12'h0;
  logic [31:0] o_rd_data;
  logic o_line_out;
  logic o_line_oe;
  logic o_convert_start;
  logic o_low_voltage_bus;
  logic [2:0] o_protocol_select;
  logic ecu_pull;
  wire logic line;
  int bad_count = 0;
  int cmp_count = 0;
  logic [31:0] q;
  logic [15:0] seq [2];
  cfg_t c;
  always #12.5 i_clk_sys = ~i_clk_sys;
  // Pull-up wins unless someone pulls low
  assign line = !(o_line_oe && !o_line_out) && !ecu_pull;
  sensor_link_top sensor_link_top_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_bus(i_bus), .o_rd_data(o_rd_data), .i_line(line), .o_line_out(o_line_out),
    .o_line_oe(o_line_oe), .i_sample(i_sample), .o_convert_start(o_convert_start),
    .o_low_voltage_bus(o_low_voltage_bus), .o_protocol_select(o_protocol_select));
  ecu_master_model ecu_master_model_inst (.i_clk_sys(i_clk_sys), .i_line(line),
    .o_pull(ecu_pull));
  task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    i_bus <= '{addr: a, wdata: d, wr_stb: 1'b1, rd_stb: 1'b0};
    @(posedge i_clk_sys);
    i_bus <= '0;
    @(posedge i_clk_sys);
  endtask
  task automatic rd(input logic [3:0] a);
    i_bus <= '{addr: a, wdata: 32'h0, wr_stb: 1'b0, rd_stb: 1'b1};
    @(posedge i_clk_sys);
    i_bus <= '0;
    #1;
    q = o_rd_data;
    @(posedge i_clk_sys);
  endtask
  function automatic logic [3:0] crc_add(input logic [3:0] c, input logic [3:0] n);
    logic fb;
    for (int i = 3; i >= 0; i--) begin
      fb = c[3] ^ n[i];
      c = {c[2:0], 1'b0} ^ {fb, fb, 1'b0, fb};
    end
    return c;
  endfunction
  function automatic logic [15:0] ssm_seq(input logic [3:0] id, input logic [7:0] b);
    return {id, b, crc_add(crc_add(crc_add(crc_add(4'h5, id), b[7:4]), b[3:0]), 4'h0)};
  endfunction
  // One polled frame compared nibble by nibble
  task automatic frame(input int low, input int ut, input int trig, input logic [3:0] st,
                       input logic cov, input logic [11:0] d);
    logic [3:0] k;
    k = cov ? crc_add(4'h5, st) : 4'h5;
    k = crc_add(crc_add(crc_add(crc_add(k, d[11:8]), d[7:4]), d[3:0]), 4'h0);
    ecu_master_model_inst.poll(low, ut);
    expect_eq(32'(ecu_master_model_inst.got), 32'h1);
    expect_eq(32'(ecu_master_model_inst.gap_ut[0]), 32'(trig));
    expect_eq(32'(ecu_master_model_inst.gap_ut[1]), 32'h38);
    expect_eq(32'(ecu_master_model_inst.gap_ut[2] - 12), 32'(st));
    for (int i = 0; i < 3; i++) begin
      expect_eq(32'(ecu_master_model_inst.gap_ut[3 + i] - 12), 32'(d[11 - 4 * i -: 4]));
    end
    expect_eq(32'(ecu_master_model_inst.gap_ut[6] - 12), 32'(k));
  endtask
  task automatic silent(input int low, input int ut);
    ecu_master_model_inst.poll(low, ut);
    expect_eq(32'(ecu_master_model_inst.got), 32'h0);
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Longest expected run is about 85000 clocks
  initial begin
    repeat (98000) @(posedge i_clk_sys);
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    rd(REG_CONFIG);
    expect_eq(q, 32'h0010_0010);
    wr(4'hF, 32'hFFFF_FFFF);
    rd(REG_CONFIG);
    expect_eq(q, 32'h0010_0010);
    rd(4'hF);
    expect_eq(q, 32'h0);
    wr(REG_USER_TAGS, 32'h0000_C3A5);
    rd(REG_USER_TAGS);
    expect_eq(q, 32'h0000_C3A5);
    wr(REG_SSM_FIRST, 32'h0000_00A5);
    wr(REG_SSM_FIRST + 4'h1, 32'h0000_003C);
    rd(REG_SSM_FIRST);
    expect_eq(q, 32'h0);
    for (int p = 0; p < 5; p++) begin
      c = CFG_RESET;
      c.main_protocol_select = 3'(p);
      c.sub_protocol_select = 3'(p);
      c.low_voltage_bus_enable = p[0];
      wr(REG_CONFIG, 32'(c));
      repeat (3) @(posedge i_clk_sys);
      expect_eq(32'(o_protocol_select), 32'(p));
      expect_eq(32'(o_low_voltage_bus), 32'(p[0]));
    end
    c = CFG_RESET;
    c.unit_time_code = UT_CODE_0P50;
    c.variable_trigger_length = 1'b1;
    c.side_channel_message_enable = 1'b1;
    c.main_bus_address = 2'h2;
    c.sub_bus_address = 2'h2;
    c.sync_hold_address = 2'h2;
    wr(REG_CONFIG, 32'(c));
    seq[0] = ssm_seq(4'h0, 8'hA5);
    seq[1] = ssm_seq(4'h1, 8'h3C);
    // Twenty frames reach into the second message to see its id
    for (int f = 0; f < 20; f++) begin
      frame(10, 20, 22, {2'h2, f % 16 == 0, seq[f / 16][15 - f % 16]}, 1'b1, 12'h0);
    end
    c = CFG_RESET;
    c.unit_time_code = UT_CODE_0P75;
    c.crc_covers_status = 1'b0;
    c.main_bus_address = 2'h3;
    c.sub_bus_address = 2'h3;
    c.sync_hold_address = 2'h3;
    wr(REG_CONFIG, 32'(c));
    i_sample <= 12'h5A3;
    frame(10, 30, 90, 4'hC, 1'b0, 12'h5A3);
    c = CFG_RESET;
    c.unit_time_code = UT_CODE_0P50;
    // fast unit time in bus mode
    c.variable_trigger_length = 1'b1;
    c.addressed_bus_select = 1'b1;
    c.main_bus_address = 2'h1;
    c.sub_bus_address = 2'h1;
    c.sync_hold_address = 2'h1;
    wr(REG_CONFIG, 32'(c));
    i_sample <= 12'h456;
    silent(10, 20);
    frame(26, 20, 38, 4'h4, 1'b1, 12'h456);
    c.sync_hold_address = 2'h0;
    wr(REG_CONFIG, 32'(c));
    i_sample <= 12'h123;
    silent(10, 20);
    i_sample <= 12'h789;
    frame(26, 20, 38, 4'h4, 1'b1, 12'h123);
    print_verdict();
  end
endmodule

// ### sim/sensor_link_chk.sv
// Port checker of the sensor link top.
// Assumes one clock domain and a bind onto sensor_link_top.
`timescale 1ns/10ps
module sensor_link_chk
  import sensor_link_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Register port
  input wire bus_req_t i_bus,
  input wire logic [31:0] o_rd_data,
  // Link and signal path
  input wire logic i_line,
  input wire logic o_line_out,
  input wire logic o_line_oe,
  input wire logic [11:0] i_sample,
  input wire logic o_convert_start,
  input wire logic o_low_voltage_bus,
  input wire logic [2:0] o_protocol_select
);
  cfg_t shadow;
  logic [15:0] tags;
  logic tags_set;
  logic [1:0] age;
  default clocking dc @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // Mirror of what software wrote, so readback and levels can be judged
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      shadow <= CFG_RESET;
      tags <= 16'h0;
      tags_set <= 1'b0;
      age <= 2'h0;
    end else begin
      if (i_bus.wr_stb && i_bus.addr == REG_CONFIG) begin
        shadow <= cfg_t'(i_bus.wdata[CFG_W-1:0]);
        age <= 2'h0;
      end else if (age != 2'h3) begin
        age <= age + 2'h1;
      end
      if (i_bus.wr_stb && i_bus.addr == REG_USER_TAGS) begin
        tags <= i_bus.wdata[15:0];
        tags_set <= 1'b1;
      end
    end
  end
  sequence cfg_read_s;
    i_bus.rd_stb && i_bus.addr == REG_CONFIG;
  endsequence
  sequence tag_read_s;
    i_bus.rd_stb && i_bus.addr == REG_USER_TAGS && tags_set;
  endsequence
  line_out_low_a: assert property (o_line_out == 1'b0)
    else $error("line data output not low");
  rd_idle_zero_a: assert property (!i_bus.rd_stb |=> o_rd_data == 32'h0)
    else $error("read data without read");
  cfg_readback_a: assert property (cfg_read_s |=> o_rd_data == {11'h0, shadow})
    else $error("config readback wrong");
  tag_readback_a: assert property (tag_read_s |=> o_rd_data == {16'h0, tags})
    else $error("user tag readback wrong");
  ssm_write_only_a: assert property (i_bus.rd_stb && i_bus.addr >= REG_SSM_FIRST &&
    i_bus.addr <= REG_SSM_LAST |=> o_rd_data == 32'h0)
    else $error("message byte readable");
  unmapped_read_a: assert property (i_bus.rd_stb && i_bus.addr > REG_STATUS
    |=> o_rd_data == 32'h0)
    else $error("unmapped read not zero");
  proto_follows_a: assert property (age == 2'h3 |-> o_protocol_select == shadow.main_protocol_select)
    else $error("protocol output wrong");
  lv_follows_a: assert property (age == 2'h3 |-> o_low_voltage_bus == shadow.low_voltage_bus_enable)
    else $error("low voltage output wrong");
  convert_single_a: assert property (o_convert_start |=> !o_convert_start)
    else $error("convert pulse too long");
  oe_after_release_a: assert property ($rose(o_line_oe) |-> $past(i_line))
    else $error("device pulled a low line");
  pulse_min_a: assert property ($rose(o_line_oe) |-> o_line_oe [*8])
    else $error("line pulse too short");
endmodule

bind sensor_link_top sensor_link_chk sensor_link_chk_inst (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_bus(i_bus), .o_rd_data(o_rd_data),
  .i_line(i_line), .o_line_out(o_line_out), .o_line_oe(o_line_oe), .i_sample(i_sample),
  .o_convert_start(o_convert_start), .o_low_voltage_bus(o_low_voltage_bus),
  .o_protocol_select(o_protocol_select)
);

// ### verilog/sensor_link_pkg.sv
// Shared constants, types and helpers of the pulse-coded sensor link.
// Assumes a single 40 MHz system clock and a plain register port.
package sensor_link_pkg;

  // Clock and unit-time figures
  localparam int CLK_FREQ_MHZ = 40;
  localparam int UT_NS_0P50 = 500;
  localparam int UT_NS_0P75 = 750;
  localparam int UT_NS_1P00 = 1000;
  localparam int UT_NS_1P25 = 1250;
  localparam int UT_NS_1P50 = 1500;
  localparam int UT_NS_2P00 = 2000;
  localparam int UT_NS_2P50 = 2500;
  localparam int UT_NS_3P00 = 3000;
  localparam int UT_CYC_0P50 = UT_NS_0P50 * CLK_FREQ_MHZ / 1000;
  localparam int UT_CYC_0P75 = UT_NS_0P75 * CLK_FREQ_MHZ / 1000;
  localparam int UT_CYC_1P00 = UT_NS_1P00 * CLK_FREQ_MHZ / 1000;
  localparam int UT_CYC_1P25 = UT_NS_1P25 * CLK_FREQ_MHZ / 1000;
  localparam int UT_CYC_1P50 = UT_NS_1P50 * CLK_FREQ_MHZ / 1000;
  localparam int UT_CYC_2P00 = UT_NS_2P00 * CLK_FREQ_MHZ / 1000;
  localparam int UT_CYC_2P50 = UT_NS_2P50 * CLK_FREQ_MHZ / 1000;
  localparam int UT_CYC_3P00 = UT_NS_3P00 * CLK_FREQ_MHZ / 1000;

  // Unit-time codes
  localparam logic [3:0] UT_CODE_0P50 = 4'h1;
  localparam logic [3:0] UT_CODE_0P75 = 4'h2;
  localparam logic [3:0] UT_CODE_1P00 = 4'h3;
  localparam logic [3:0] UT_CODE_1P25 = 4'h4;
  localparam logic [3:0] UT_CODE_1P50 = 4'h5;
  localparam logic [3:0] UT_CODE_2P00 = 4'h6;
  localparam logic [3:0] UT_CODE_2P50 = 4'h7;
  localparam logic [3:0] UT_CODE_3P00 = 4'h8;

  // Frame timing in unit times, and nibble slot indices
  localparam logic [7:0] TRIG_CONST_UT = 8'h5A;
  localparam logic [7:0] TRIG_VAR_EXTRA_UT = 8'h0C;
  localparam logic [7:0] SYNC_UT = 8'h38;
  localparam logic [7:0] NIB_BASE_UT = 8'h0C;
  localparam logic [7:0] LOW_UT = 8'h04;
  localparam logic [7:0] ADDR_LOW_BASE_UT = 8'h08;
  localparam logic [7:0] ADDR_LOW_STEP_UT = 8'h0E;
  localparam logic [2:0] NIB_SYNC = 3'h0;
  localparam logic [2:0] NIB_CRC = 3'h5;
  localparam logic [2:0] NIB_END = 3'h6;

  // Side-channel message
  localparam logic [3:0] SSM_LAST_FRAME = 4'hF;
  localparam logic [2:0] SSM_LAST_MSG = 3'h4;
  localparam int SSM_MSG_COUNT = 5;
  localparam logic [3:0] CRC_SEED = 4'h5;
  localparam logic [3:0] CRC_POLY = 4'hD;

  // Register indices
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_USER_TAGS = 4'h1;
  localparam logic [3:0] REG_SSM_FIRST = 4'h2;
  localparam logic [3:0] REG_SSM_LAST = 4'h6;
  localparam logic [3:0] REG_STATUS = 4'h7;

  // Configuration word, first field at bit 20, packed downward to bit 0
  typedef struct packed {
    logic [3:0] unit_time_code;
    logic addressed_bus_select;
    logic variable_trigger_length;
    logic [1:0] sync_hold_address;
    logic [2:0] sub_protocol_select;
    logic [2:0] main_protocol_select;
    logic low_voltage_bus_enable;
    logic side_channel_message_enable;
    logic crc_covers_status;
    logic [1:0] sub_bus_address;
    logic [1:0] main_bus_address;
  } cfg_t;

  localparam int CFG_W = 21;
  localparam cfg_t CFG_RESET = '{unit_time_code: UT_CODE_3P00, crc_covers_status: 1'b1,
                                 default: '0};

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr_stb;
    logic rd_stb;
  } bus_req_t;

  // One CRC step over a nibble, msb first
  function automatic logic [3:0] crc4_step(input logic [3:0] crc, input logic [3:0] nib);
    logic [3:0] c;
    logic fb;
    c = crc;
    for (int i = 3; i >= 0; i--) begin
      fb = c[3] ^ nib[i];
      c = {c[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0);
    end
    return c;
  endfunction

  // Cycles per unit time; undefined codes fall back to the default rate
  function automatic logic [7:0] ut_cycles(input logic [3:0] code);
    case (code)
      UT_CODE_0P50: return 8'(UT_CYC_0P50);
      UT_CODE_0P75: return 8'(UT_CYC_0P75);
      UT_CODE_1P00: return 8'(UT_CYC_1P00);
      UT_CODE_1P25: return 8'(UT_CYC_1P25);
      UT_CODE_1P50: return 8'(UT_CYC_1P50);
      UT_CODE_2P00: return 8'(UT_CYC_2P00);
      UT_CODE_2P50: return 8'(UT_CYC_2P50);
      default: return 8'(UT_CYC_3P00);
    endcase
  endfunction

endpackage

// ### verilog/sensor_link_top.sv
// Triggered single-wire pulse-coded output link of a field sensor.
// Assumes an open-drain line pulled high outside, and a conversion
// result on i_sample from logic on the same clock.
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps

// Functional notes
// - Frames carry the 2-bit bus address from configuration, default 00.
// - User tags are stored and read back only, never used.
// - CRC covers status nibble when coverage bit is 1, else it is skipped.
// - Side-channel enable sends 16-bit sequence, one bit per frame.
// - Status bit 1 is 1 on a sequence's first frame, 0 for 15 more.
// - Sequence is 4-bit id, data byte, 4-bit CRC of the same algorithm.
// - Payload rides status bit 0, bit 15 first down to bit 0.
// - Message ids run 0 to 4 and then wrap to 0.
// - Low-voltage bus bit, default 0, meant only for unit time >= 1 us.
// - Protocol select is a 3-bit code 000 to 100, main equals sub.
// - Trigger to sync-hold address converts; if equal to bus address, answer.
// - Otherwise hold the sample and answer it when polled by bus address.
// - Sync-hold address is 2 bits; equal to bus address disables holding.
// - Trigger length is 90 UT, or low time plus 12 UT when variable.
// - Address comes only from the trigger's low duration.
// - Bus mode bit 0 is synchronous mode, 1 is addressed bus mode.
// - Unit-time code 0001..1000 selects 0.5 to 3.0 us, default 1000.
module sensor_link_top
  import sensor_link_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Register port
  input wire bus_req_t i_bus,
  output logic [31:0] o_rd_data,
  // Open-drain link line
  input wire logic i_line,
  output logic o_line_out,
  output logic o_line_oe,
  // Signal path
  input wire logic [11:0] i_sample,
  output logic o_convert_start,
  output logic o_low_voltage_bus,
  output logic [2:0] o_protocol_select
);
  typedef enum logic [1:0] {IDLE, TRIG_LOW, TRIG_WAIT, TX} fsm_t;

  typedef struct packed {
    fsm_t fsm;
    cfg_t cfg;
    logic [15:0] user_tags;
    logic line_meta;
    logic line_sync;
    logic line_prev;
    logic [7:0] ut_cnt;
    logic [7:0] low_len;
    logic [2:0] nib_idx;
    logic oe;
    logic reply;
    logic [11:0] held;
    logic held_valid;
    logic [11:0] data;
    logic [3:0] status;
    logic [3:0] crc;
    logic [3:0] ssm_frame;
    logic [2:0] msg_id;
    logic [1:0] last_addr;
    logic convert;
    logic [31:0] rd_data;
  } state_t;

  state_t st;
  state_t next_st;
  logic tick;
  logic restart;
  logic [7:0] ssm_byte;
  logic ssm_wr;
  logic [3:0] ssm_wr_idx;

  assign ssm_wr = i_bus.wr_stb && (i_bus.addr >= REG_SSM_FIRST) && (i_bus.addr <= REG_SSM_LAST);
  assign ssm_wr_idx = i_bus.addr - REG_SSM_FIRST;
  assign restart = (st.fsm == IDLE) && st.line_prev && !st.line_sync;

  ut_tick_gen u_ut (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_restart(restart),
    .i_period(ut_cycles(st.cfg.unit_time_code)),
    .o_tick(tick)
  );

  ssm_store #(.DEPTH(SSM_MSG_COUNT), .WIDTH(8)) u_ssm (
    .i_clk_sys(i_clk_sys),
    .i_wr_en(ssm_wr),
    .i_wr_addr(ssm_wr_idx[2:0]),
    .i_wr_data(i_bus.wdata[7:0]),
    .i_rd_addr(st.msg_id),
    .o_rd_data(ssm_byte)
  );

  // Address from trigger low length; 3'h4 means no valid address
  function automatic logic [2:0] decode_addr(input logic [7:0] len);
    logic [2:0] a;
    a = 3'h4;
    for (int n = 3; n >= 0; n--) begin
      if (len >= ADDR_LOW_BASE_UT + 8'(n) * ADDR_LOW_STEP_UT &&
          len < ADDR_LOW_BASE_UT + 8'(n + 1) * ADDR_LOW_STEP_UT && a == 3'h4) begin
        a = 3'(n);
      end
    end
    return a;
  endfunction

  // Nibble period in unit times for the current slot
  function automatic logic [7:0] nib_period(input logic [2:0] idx, input state_t s);
    case (idx)
      NIB_SYNC: return SYNC_UT;
      3'h1: return NIB_BASE_UT + {4'h0, s.status};
      3'h2: return NIB_BASE_UT + {4'h0, s.data[11:8]};
      3'h3: return NIB_BASE_UT + {4'h0, s.data[7:4]};
      3'h4: return NIB_BASE_UT + {4'h0, s.data[3:0]};
      NIB_CRC: return NIB_BASE_UT + {4'h0, s.crc};
      default: return LOW_UT;
    endcase
  endfunction

  always_comb begin
    logic [2:0] addr;
    logic fh_enabled;
    logic [7:0] trig_len;
    logic [15:0] seq;
    logic [3:0] stat;
    logic [3:0] c;
    logic [11:0] d;
    addr = decode_addr(st.low_len);
    // holding only when the addresses differ
    fh_enabled = st.cfg.sync_hold_address != st.cfg.main_bus_address;
    trig_len = st.cfg.variable_trigger_length ? st.low_len + TRIG_VAR_EXTRA_UT : TRIG_CONST_UT;
    // message id, data byte, CRC nibble
    c = crc4_step(crc4_step(crc4_step(CRC_SEED, {1'b0, st.msg_id}), ssm_byte[7:4]),
                  ssm_byte[3:0]);
    seq = {1'b0, st.msg_id, ssm_byte, crc4_step(c, 4'h0)};
    // bus address in the status nibble
    stat = {st.cfg.main_bus_address, 2'b00};
    if (st.cfg.side_channel_message_enable) begin
      stat[1] = st.ssm_frame == 4'h0;
      // payload in bit 0, msb first
      stat[0] = seq[4'hF - st.ssm_frame];
    end
    d = st.reply && st.held_valid ? st.held : i_sample;

    next_st = st;
    next_st.line_meta = i_line;
    next_st.line_sync = st.line_meta;
    next_st.line_prev = st.line_sync;
    next_st.convert = 1'b0;
    next_st.rd_data = 32'h0000_0000;

    case (st.fsm)
      IDLE: begin
        next_st.oe = 1'b0;
        if (restart) begin
          next_st.fsm = TRIG_LOW;
          next_st.ut_cnt = 8'h00;
        end
      end
      TRIG_LOW: begin
        if (tick && st.ut_cnt != 8'hFF) begin
          next_st.ut_cnt = st.ut_cnt + 8'h01;
        end
        // address taken from the low phase alone
        // Round up: the tick phase trails the synchronised falling edge
        if (st.line_sync) begin
          next_st.low_len = (st.ut_cnt == 8'hFF) ? 8'hFF : st.ut_cnt + 8'h01;
          next_st.fsm = TRIG_WAIT;
          next_st.nib_idx = NIB_SYNC;
        end
      end
      TRIG_WAIT: begin
        if (tick) begin
          next_st.ut_cnt = st.ut_cnt + 8'h01;
        end
        if (st.nib_idx != NIB_END) begin
          // First cycle after the rise: decide what this trigger means
          next_st.nib_idx = NIB_END;
          if (!st.cfg.addressed_bus_select) begin
            next_st.convert = 1'b1;
            next_st.reply = 1'b1;
            next_st.held_valid = 1'b0;
          end else if (addr != 3'h4) begin
            next_st.last_addr = addr[1:0];
            if (fh_enabled && addr[1:0] == st.cfg.sync_hold_address) begin
              // capture and keep for a later poll
              next_st.convert = 1'b1;
              next_st.held = i_sample;
              next_st.held_valid = 1'b1;
              next_st.reply = 1'b0;
            end else if (addr[1:0] == st.cfg.main_bus_address) begin
              // answer at once, or answer the held sample
              next_st.convert = !st.held_valid;
              next_st.reply = 1'b1;
            end else begin
              next_st.reply = 1'b0;
            end
          end else begin
            next_st.reply = 1'b0;
          end
        end
        // Leave on the tick itself so the first pulse keeps tick alignment
        if (st.nib_idx == NIB_END && tick && st.ut_cnt + 8'h01 >= trig_len) begin
          if (st.reply) begin
            // optional status coverage in the frame CRC
            c = st.cfg.crc_covers_status ? crc4_step(CRC_SEED, stat) : CRC_SEED;
            c = crc4_step(crc4_step(crc4_step(c, d[11:8]), d[7:4]), d[3:0]);
            next_st.crc = crc4_step(c, 4'h0);
            next_st.status = stat;
            next_st.data = d;
            next_st.held_valid = 1'b0;
            next_st.fsm = TX;
            next_st.ut_cnt = 8'h00;
            next_st.nib_idx = NIB_SYNC;
            next_st.oe = 1'b1;
            if (st.cfg.side_channel_message_enable) begin
              next_st.ssm_frame = st.ssm_frame + 4'h1;
              // wrap after the last message id
              if (st.ssm_frame == SSM_LAST_FRAME) begin
                next_st.msg_id = st.msg_id == SSM_LAST_MSG ? 3'h0 : st.msg_id + 3'h1;
              end
            end else begin
              next_st.ssm_frame = 4'h0;
              next_st.msg_id = 3'h0;
            end
          end else begin
            next_st.fsm = IDLE;
            next_st.nib_idx = NIB_SYNC;
          end
        end
      end
      TX: begin
        if (tick) begin
          next_st.ut_cnt = st.ut_cnt + 8'h01;
          next_st.oe = st.ut_cnt + 8'h01 < LOW_UT;
          if (st.ut_cnt + 8'h01 >= nib_period(st.nib_idx, st)) begin
            next_st.ut_cnt = 8'h00;
            if (st.nib_idx == NIB_END) begin
              next_st.fsm = IDLE;
              next_st.oe = 1'b0;
              next_st.nib_idx = NIB_SYNC;
            end else begin
              next_st.nib_idx = st.nib_idx + 3'h1;
              next_st.oe = 1'b1;
            end
          end
        end
      end
      default: begin
        next_st.fsm = IDLE;
      end
    endcase

    if (i_bus.wr_stb) begin
      case (i_bus.addr)
        REG_CONFIG: next_st.cfg = cfg_t'(i_bus.wdata[CFG_W-1:0]);
        REG_USER_TAGS: next_st.user_tags = i_bus.wdata[15:0];
        default: begin
        end
      endcase
    end
    if (i_bus.rd_stb) begin
      case (i_bus.addr)
        REG_CONFIG: next_st.rd_data = {11'h000, st.cfg};
        REG_USER_TAGS: next_st.rd_data = {16'h0000, st.user_tags};
        REG_STATUS: next_st.rd_data = {16'h0000, st.ssm_frame, 1'b0, st.msg_id,
                                       st.last_addr, st.held_valid, st.reply,
                                       2'b00, st.fsm};
        default: next_st.rd_data = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      st <= '0;
      st.cfg <= CFG_RESET;
      st.line_meta <= 1'b1;
      st.line_sync <= 1'b1;
      st.line_prev <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_rd_data = st.rd_data;
  assign o_line_out = 1'b0;
  assign o_line_oe = st.oe;
  assign o_convert_start = st.convert;
  // level handed to the output driver
  assign o_low_voltage_bus = st.cfg.low_voltage_bus_enable;
  // protocol code handed to the frame formatter
  assign o_protocol_select = st.cfg.main_protocol_select;
endmodule

// ### verilog/ssm_store.sv
// Small store for the data bytes of the side-channel messages.
// Read data are registered, so they follow the address by one cycle.
`timescale 1ns/10ps
module ssm_store #(
  parameter int DEPTH = 5,
  parameter int WIDTH = 8
) (
  // Clock
  input wire logic i_clk_sys,
  // Write port
  input wire logic i_wr_en,
  input wire logic [2:0] i_wr_addr,
  input wire logic [WIDTH-1:0] i_wr_data,
  // Read port
  input wire logic [2:0] i_rd_addr,
  output logic [WIDTH-1:0] o_rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge i_clk_sys) begin
    if (i_wr_en && (int'(i_wr_addr) < DEPTH)) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= (int'(i_rd_addr) < DEPTH) ? mem[i_rd_addr] : '0;
  end
endmodule

// ### verilog/ut_tick_gen.sv
// Unit-time divider: one-cycle tick every i_period system clocks.
// Assumes i_period is at least 2 and restarts align ticks to a line edge.
`timescale 1ns/10ps
module ut_tick_gen (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Control
  input wire logic i_restart,
  input wire logic [7:0] i_period,
  // Tick
  output logic o_tick
);
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } div_t;

  div_t st;
  div_t next_st;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (i_restart) begin
      next_st.cnt = 8'h00;
    end else if (st.cnt >= i_period - 8'h01) begin
      next_st.cnt = 8'h00;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 8'h01;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_tick = st.tick;
endmodule
